// *** ltds_defines.svh ***
// Operation
// RULE_01: Date order selectable, default day-month-year.
// RULE_02: Country code selects calendar, default United States; the code only reports it in STATUS.
// RULE_03: Daylight saving off: standard time only.
// RULE_04: Daylight saving on: advance and retard one hour; the code skips the retard when the end hour is 0.
// RULE_05: Start point month/week/day/hour, default March second Sunday 2.
// RULE_06: End point month/week/day/hour, default November first Sunday 2.
// RULE_07: Week selector first to fourth or last.
// RULE_08: Sync source none or one of six inputs.
// RULE_09: Sync edge rounds clock to nearest minute.
// RULE_10: Each transition applied once per year.
`ifndef LTDS_DEFINES_SVH
`define LTDS_DEFINES_SVH

// ==========================================
// Register offsets
`define LTDS_OFS_CTRL     8'h00
`define LTDS_OFS_START    8'h04
`define LTDS_OFS_END      8'h08
`define LTDS_OFS_TIME     8'h0c
`define LTDS_OFS_DATE     8'h10
`define LTDS_OFS_PRESENT  8'h14
`define LTDS_OFS_STATUS   8'h18

// ==========================================
// Reset values
`define LTDS_RST_CTRL     32'h0000_0000
`define LTDS_RST_START    32'h0200_0203
`define LTDS_RST_END      32'h0200_010b

// ==========================================
// Field positions
`define LTDS_CTRL_DST_BIT     0
`define LTDS_CTRL_ORDER_LSB   1
`define LTDS_CTRL_SYNC_LSB    4
`define LTDS_CTRL_CNTRY_LSB   8

// ==========================================
// Timing
`define LTDS_CLK_HZ       40000000
`define LTDS_SEC_NS       1000000000
`define LTDS_CLK_NS       25
`define LTDS_SEC_CYCLES   (`LTDS_SEC_NS / `LTDS_CLK_NS)
`define LTDS_WEEK_LAST    3'h5

`endif

// *** ltds_pkg.sv ***
package ltds_pkg;
    typedef enum logic [1:0] {
        LTDS_ORDER_DMY = 2'b00,
        LTDS_ORDER_MDY = 2'b01,
        LTDS_ORDER_YMD = 2'b10
    } ltds_order_t;

    typedef enum logic [1:0] {
        LTDS_ST_STD  = 2'b00,
        LTDS_ST_DST  = 2'b01,
        LTDS_ST_HOLD = 2'b10
    } ltds_state_t;
endpackage

// *** ltds_sync_in.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Three-stage pin synchroniser with rising-edge pulse
module ltds_sync_in (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Pin and pulse
    input  wire logic pin,
    output logic      rise
);
    logic [2:0] sh_q;
    logic       lvl_q;
    logic       lvl_d;

    // Stable once second and third agree
    always_comb begin
        lvl_d = lvl_q;
        if (sh_q[1] == sh_q[2]) begin
            lvl_d = sh_q[2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_q  <= 3'h0;
            lvl_q <= 1'b0;
        end else begin
            sh_q  <= {sh_q[1:0], pin};
            lvl_q <= lvl_d;
        end
    end

    assign rise = lvl_d & ~lvl_q;
endmodule
`default_nettype wire

// *** ltds_ahb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// AHB-Lite front end: captures address phase, zero wait states
module ltds_ahb_slave (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Bus
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    // Register side
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [7:0]       rd_addr
);
    logic       wp_q;
    logic       wp_d;
    logic [7:0] a_q;
    logic [7:0] a_d;

    // Capture address phase of a valid transfer
    always_comb begin
        wp_d = 1'b0;
        a_d  = a_q;
        if (hsel && hready && htrans[1]) begin
            wp_d = hwrite;
            a_d  = haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= 1'b0;
            a_q  <= 8'h00;
        end else begin
            wp_q <= wp_d;
            a_q  <= a_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_en     = wp_q;
    assign wr_addr   = a_q;
    assign rd_addr   = haddr;
endmodule
`default_nettype wire

// *** ltds_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ltds_defines.svh"
// ==========================================
// Local time keeper with daylight saving and minute sync
module ltds_core (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Digital inputs one to six
    input  wire logic [5:0]  din,
    // Second tick out
    output logic             sec_tick
);
    import ltds_pkg::*;

    // ==========================================
    // Helpers
    function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
        logic [4:0] d;
        d = 5'd31;
        if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11) begin
            d = 5'd30;
        end else if (m == 4'd2) begin
            d = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
        end
        return d;
    endfunction

    // Week number of a date, last week flagged separately
    function automatic logic week_hit(input logic [2:0] wsel, input logic [4:0] day,
                                      input logic [4:0] dim);
        logic h;
        h = 1'b0;
        if (wsel == `LTDS_WEEK_LAST) begin
            // Fewer than seven days left; no wrap near day 31
            h = (day > 5'(dim - 5'd7));
        end else if (wsel >= 3'd1 && wsel <= 3'd4) begin
            h = (3'((day - 5'd1) / 5'd7) == 3'(wsel - 3'd1));
        end
        return h;
    endfunction

    // ==========================================
    // Bus front end
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;

    ltds_ahb_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .rd_addr   (rd_addr)
    );

    // ==========================================
    // Sync pin conditioning
    logic [5:0] din_rise;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
            ltds_sync_in u_sync (
                .hclk    (hclk),
                .hresetn (hresetn),
                .pin     (din[gi]),
                .rise    (din_rise[gi])
            );
        end
    endgenerate

    // ==========================================
    // Configuration registers
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] start_q, start_d;
    logic [31:0] end_q, end_d;
    logic        tw_en;
    logic        dw_en;

    always_comb begin
        ctrl_d  = ctrl_q;
        start_d = start_q;
        end_d   = end_q;
        tw_en   = 1'b0;
        dw_en   = 1'b0;
        if (wr_en) begin
            case (wr_addr)
                `LTDS_OFS_CTRL:  ctrl_d  = hwdata;
                `LTDS_OFS_START: start_d = hwdata;
                `LTDS_OFS_END:   end_d   = hwdata;
                `LTDS_OFS_TIME:  tw_en   = 1'b1;
                `LTDS_OFS_DATE:  dw_en   = 1'b1;
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= `LTDS_RST_CTRL;
            start_q <= `LTDS_RST_START;
            end_q   <= `LTDS_RST_END;
        end else begin
            ctrl_q  <= ctrl_d;
            start_q <= start_d;
            end_q   <= end_d;
        end
    end

    // RULE_03 daylight option flag
    logic        dst_on;
    ltds_order_t order;
    logic [2:0]  sync_sel;
    logic [7:0]  country;
    assign dst_on   = ctrl_q[`LTDS_CTRL_DST_BIT];
    assign order    = ltds_order_t'(ctrl_d[`LTDS_CTRL_ORDER_LSB +: 2]);
    assign sync_sel = ctrl_q[`LTDS_CTRL_SYNC_LSB +: 3];
    assign country  = ctrl_d[`LTDS_CTRL_CNTRY_LSB +: 8];

    // RULE_08 sync source select
    logic sync_ev;
    assign sync_ev = (sync_sel >= 3'd1 && sync_sel <= 3'd6) ? din_rise[sync_sel - 3'd1] : 1'b0;

    // ==========================================
    // Time keeping
    logic [25:0] pre_q, pre_d;
    logic [5:0]  sec_q, sec_d;
    logic [5:0]  min_q, min_d;
    logic [4:0]  hr_q, hr_d;
    logic [4:0]  day_q, day_d;
    logic [3:0]  mon_q, mon_d;
    logic [6:0]  yr_q, yr_d;
    logic [2:0]  wd_q, wd_d;
    ltds_state_t st_q, st_d;
    logic        tick;
    logic [4:0]  dim;
    logic        at_start;
    logic        at_end;
    logic        sync_up;

    assign tick = (pre_q == 26'(`LTDS_SEC_CYCLES - 1));
    // RULE_09 upper half rounds up through the carry chain
    assign sync_up = sync_ev && (sec_q >= 6'd30);
    assign dim  = days_in(mon_q, yr_q);

    // RULE_05 RULE_07 start point match
    assign at_start = (mon_q == start_q[3:0]) && (wd_q == start_q[18:16])
                      && week_hit(start_q[10:8], day_q, dim)
                      && (hr_q == start_q[28:24]) && (min_q == 6'd0);
    // RULE_06 RULE_07 end point match
    assign at_end   = (mon_q == end_q[3:0]) && (wd_q == end_q[18:16])
                      && week_hit(end_q[10:8], day_q, dim)
                      && (hr_q == end_q[28:24]) && (min_q == 6'd0);

    always_comb begin
        pre_d = tick ? 26'h0 : 26'(pre_q + 26'h1);
        sec_d = sec_q;
        min_d = min_q;
        hr_d  = hr_q;
        day_d = day_q;
        mon_d = mon_q;
        yr_d  = yr_q;
        wd_d  = wd_q;
        st_d  = st_q;
        if (tick || sync_up) begin
            sec_d = 6'(sec_q + 6'd1);
            if (sec_q == 6'd59 || sync_up) begin
                sec_d = 6'd0;
                min_d = 6'(min_q + 6'd1);
                if (min_q == 6'd59) begin
                    min_d = 6'd0;
                    hr_d  = 5'(hr_q + 5'd1);
                    if (hr_q == 5'd23) begin
                        hr_d  = 5'd0;
                        wd_d  = (wd_q == 3'd6) ? 3'd0 : 3'(wd_q + 3'd1);
                        day_d = 5'(day_q + 5'd1);
                        if (day_q == dim) begin
                            day_d = 5'd1;
                            mon_d = 4'(mon_q + 4'd1);
                            if (mon_q == 4'd12) begin
                                mon_d = 4'd1;
                                yr_d  = (yr_q == 7'd99) ? 7'd0 : 7'(yr_q + 7'd1);
                            end
                        end
                    end
                end
            end
        end
        // RULE_09 round to nearest minute
        if (sync_ev) begin
            pre_d = 26'h0;
            sec_d = 6'd0;
        end
        // Software time and date writes win
        if (tw_en) begin
            pre_d = 26'h0;
            sec_d = hwdata[5:0];
            min_d = hwdata[13:8];
            hr_d  = hwdata[20:16];
        end
        if (dw_en) begin
            day_d = hwdata[4:0];
            mon_d = hwdata[11:8];
            yr_d  = hwdata[22:16];
            wd_d  = hwdata[26:24];
        end
        // RULE_03 RULE_04 RULE_10 seasonal steps
        case (st_q)
            LTDS_ST_STD: begin
                if (dst_on && at_start && !tw_en) begin
                    hr_d = 5'(hr_q + 5'd1);
                    st_d = LTDS_ST_DST;
                end
            end
            LTDS_ST_DST: begin
                if (!dst_on) begin
                    st_d = LTDS_ST_STD;
                end else if (at_end && !tw_en && hr_q != 5'd0) begin
                    hr_d = 5'(hr_q - 5'd1);
                    st_d = LTDS_ST_HOLD;
                end
            end
            LTDS_ST_HOLD: begin
                // Repeated hour must not retard again
                if (!at_end) begin
                    st_d = LTDS_ST_STD;
                end
            end
            default: st_d = LTDS_ST_STD;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 26'h0;
            sec_q <= 6'd0;
            min_q <= 6'd0;
            hr_q  <= 5'd0;
            day_q <= 5'd1;
            mon_q <= 4'd1;
            yr_q  <= 7'd0;
            wd_q  <= 3'd0;
            st_q  <= LTDS_ST_STD;
        end else begin
            pre_q <= pre_d;
            sec_q <= sec_d;
            min_q <= min_d;
            hr_q  <= hr_d;
            day_q <= day_d;
            mon_q <= mon_d;
            yr_q  <= yr_d;
            wd_q  <= wd_d;
            st_q  <= st_d;
        end
    end

    // ==========================================
    // RULE_01 date presentation
    logic [31:0] present;
    always_comb begin
        case (order)
            LTDS_ORDER_MDY: present = {8'h00, 4'h0, mon_d, 3'h0, day_d, 1'b0, yr_d};
            LTDS_ORDER_YMD: present = {8'h00, 1'b0, yr_d, 4'h0, mon_d, 3'h0, day_d};
            default:        present = {8'h00, 3'h0, day_d, 4'h0, mon_d, 1'b0, yr_d};
        endcase
    end

    // RULE_02 country code reported with status
    logic [31:0] rd_d, rd_q;
    // Next values, so a write just ahead of a read is seen
    always_comb begin
        case (rd_addr)
            `LTDS_OFS_CTRL:    rd_d = ctrl_d;
            `LTDS_OFS_START:   rd_d = start_d;
            `LTDS_OFS_END:     rd_d = end_d;
            `LTDS_OFS_TIME:    rd_d = {11'h0, hr_d, 2'h0, min_d, 2'h0, sec_d};
            `LTDS_OFS_DATE:    rd_d = {5'h0, wd_d, 1'b0, yr_d, 4'h0, mon_d, 3'h0, day_d};
            `LTDS_OFS_PRESENT: rd_d = present;
            `LTDS_OFS_STATUS:  rd_d = {16'h0, country, 6'h0, st_d};
            default:           rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 32'h0;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign hrdata   = rd_q;
    assign sec_tick = tick;
endmodule
`default_nettype wire

// *** ltds_core_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ltds_defines.svh"
// ==========================================
// Port checker for the time keeper
module ltds_core_monitor (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins
    input wire logic [5:0]  din,
    input wire logic        sec_tick
);
    logic        rd_q, wr_q, cw_q, sw_q, ew_q, de_q;
    logic [7:0]  ad_q;
    logic [31:0] ctrl_q, st_q;

    // Track data phases and written values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_q, wr_q, cw_q, sw_q, ew_q, de_q} <= 6'h00;
            ad_q <= 8'h00;
            ctrl_q <= 32'h0;
            st_q <= 32'h0;
        end else begin
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            wr_q <= hsel && hready && htrans[1] && hwrite;
            ad_q <= haddr;
            if (wr_q && ad_q == `LTDS_OFS_CTRL) begin
                ctrl_q <= hwdata;
                cw_q <= 1'b1;
                de_q <= de_q | hwdata[0];
            end
            if (wr_q && ad_q == `LTDS_OFS_START) begin
                st_q <= hwdata;
                sw_q <= 1'b1;
            end
            if (wr_q && ad_q == `LTDS_OFS_END) begin
                ew_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ctrl_rst;
        rd_q && ad_q == `LTDS_OFS_CTRL && !cw_q |-> hrdata == `LTDS_RST_CTRL;
    endproperty
    a_ctrl_rst: assert property (p_ctrl_rst) else $error("ctrl reset value wrong");
    property p_start_rst;
        rd_q && ad_q == `LTDS_OFS_START && !sw_q |-> hrdata == `LTDS_RST_START;
    endproperty
    a_start_rst: assert property (p_start_rst) else $error("start reset value wrong");
    property p_end_rst;
        rd_q && ad_q == `LTDS_OFS_END && !ew_q |-> hrdata == `LTDS_RST_END;
    endproperty
    a_end_rst: assert property (p_end_rst) else $error("end reset value wrong");
    property p_ctrl_rb;
        rd_q && ad_q == `LTDS_OFS_CTRL && cw_q |-> (hrdata[15:0] & 16'hff77) == (ctrl_q[15:0] & 16'hff77);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("ctrl readback wrong");
    property p_week_rb;
        rd_q && ad_q == `LTDS_OFS_START && sw_q |-> (hrdata & 32'h1f07070f) == (st_q & 32'h1f07070f);
    endproperty
    a_week_rb: assert property (p_week_rb) else $error("start readback wrong");
    property p_country;
        rd_q && ad_q == `LTDS_OFS_STATUS |-> hrdata[15:8] == ctrl_q[15:8];
    endproperty
    a_country: assert property (p_country) else $error("country mismatch");
    property p_std_only;
        rd_q && ad_q == `LTDS_OFS_STATUS && !de_q |-> hrdata[1:0] == 2'b00;
    endproperty
    a_std_only: assert property (p_std_only) else $error("summer state while disabled");
    property p_state_legal;
        rd_q && ad_q == `LTDS_OFS_STATUS |-> hrdata[1:0] != 2'b11;
    endproperty
    a_state_legal: assert property (p_state_legal) else $error("illegal state");
    property p_time_legal;
        hsel && hready && htrans[1] && !hwrite && haddr == `LTDS_OFS_TIME
            |=> hrdata[5:0] < 6'h3c && hrdata[13:8] < 6'h3c && hrdata[20:16] < 5'h18;
    endproperty
    a_time_legal: assert property (p_time_legal) else $error("time out of range");
endmodule

bind ltds_core ltds_core_monitor u_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .din(din), .sec_tick(sec_tick));
`default_nettype wire

// *** ltds_ppm_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Minute pulse source on six inputs
module ltds_ppm_src #(
    parameter int HOLD_CYC = 12
) (
    // Clock
    input  wire logic       hclk,
    // Request
    input  wire logic       fire,
    input  wire logic [2:0] src_idx,
    // Digital inputs
    output logic [5:0]      din
);
    int cnt;

    initial begin
        din = 6'h00;
        cnt = 0;
    end

    always @(posedge hclk) begin
        if (fire) begin
            din[src_idx] <= 1'b1;
            cnt <= HOLD_CYC;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) din <= 6'h00;
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ltds_defines.svh"
// ==========================================
// Testbench
module tb_top;
    import ltds_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sec_tick, fire;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, src_idx;
    logic [31:0] hwdata, hrdata, rv, w;
    logic [5:0]  din;
    int          num_errors, n_compared, n_tick;

    ltds_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .din(din), .sec_tick(sec_tick));
    ltds_ppm_src u_src (.hclk(hclk), .fire(fire), .src_idx(src_idx), .din(din));

    // Clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // One single word transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rv = hrdata;
    endtask

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] v);
        n_compared++;
        if (v !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, v);
            num_errors++;
        end
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [7:0] a);
        bus(1'b0, a, 32'h0);
        chk_val(nm, e, rv);
    endtask

    // Seconds seen; a run this short must see none
    always @(posedge hclk) begin
        if (hresetn && sec_tick) begin
            n_tick <= n_tick + 1;
        end
    end

    function automatic logic [31:0] tm(input logic [7:0] h, m, s);
        return {8'h00, h, m, s};
    endfunction

    // Set time, pulse one input, read time back
    task automatic sync(input logic [2:0] i, input logic [31:0] t0, te);
        bus(1'b1, `LTDS_OFS_TIME, t0);
        @(posedge hclk);
        fire <= 1'b1;
        src_idx <= i;
        @(posedge hclk);
        fire <= 1'b0;
        repeat (40) @(posedge hclk);
        chk("time", te, `LTDS_OFS_TIME);
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (50000) @(posedge hclk);
        num_errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        stop_test();
    end

    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, fire} = 4'h0;
        {haddr, htrans, src_idx, hwdata} = '0;
        hsize = 3'h2;
        num_errors = 0;
        n_compared = 0;
        n_tick = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk("ctrl", 32'h0, `LTDS_OFS_CTRL);
        chk("start", 32'h02000203, `LTDS_OFS_START);
        chk("end", 32'h0200010b, `LTDS_OFS_END);
        chk("status", 32'h0, `LTDS_OFS_STATUS);
        bus(1'b1, 8'h1c, 32'hffffffff);
        chk("unmapped", 32'h0, 8'h1c);
        $display("test defaults done");
        bus(1'b1, `LTDS_OFS_DATE, 32'h03190715);
        chk("dmy", 32'h00150719, `LTDS_OFS_PRESENT);
        bus(1'b1, `LTDS_OFS_CTRL, 32'h2);
        chk("mdy", 32'h00071519, `LTDS_OFS_PRESENT);
        bus(1'b1, `LTDS_OFS_CTRL, 32'h4);
        chk("ymd", 32'h00190715, `LTDS_OFS_PRESENT);
        for (int i = 1; i <= 6; i++) begin
            w = 32'((i << 24) | (i << 16) | ((((i - 1) % 5) + 1) << 8) | (i + 6));
            bus(1'b1, `LTDS_OFS_START, w);
            chk("start", w, `LTDS_OFS_START);
            bus(1'b1, `LTDS_OFS_END, w);
            chk("end", w, `LTDS_OFS_END);
        end
        $display("test settings done");
        bus(1'b1, `LTDS_OFS_START, 32'h02000203);
        bus(1'b1, `LTDS_OFS_END, 32'h04000203);
        bus(1'b1, `LTDS_OFS_DATE, 32'h001a0308);
        bus(1'b1, `LTDS_OFS_CTRL, 32'h10);
        sync(3'h0, tm(1, 59, 40), tm(2, 0, 0));
        chk("status", 32'h0, `LTDS_OFS_STATUS);
        sync(3'h0, tm(2, 10, 20), tm(2, 10, 0));
        sync(3'h0, tm(2, 10, 30), tm(2, 11, 0));
        bus(1'b1, `LTDS_OFS_CTRL, 32'h0);
        sync(3'h1, tm(5, 10, 40), tm(5, 10, 40));
        for (int i = 1; i <= 6; i++) begin
            bus(1'b1, `LTDS_OFS_CTRL, 32'(i << 4));
            sync(3'(i % 6), tm(5, 10, 40), tm(5, 10, 40));
            sync(3'(i - 1), tm(5, 10, 40), tm(5, 11, 0));
        end
        $display("test sync done");
        bus(1'b1, `LTDS_OFS_CTRL, 32'h11);
        sync(3'h0, tm(1, 59, 40), tm(3, 0, 0));
        chk("status", 32'h1, `LTDS_OFS_STATUS);
        sync(3'h0, tm(3, 59, 50), tm(3, 0, 0));
        chk("status", 32'h0, `LTDS_OFS_STATUS);
        sync(3'h0, tm(3, 59, 45), tm(4, 0, 0));
        chk("date", 32'h001a0308, `LTDS_OFS_DATE);
        bus(1'b1, `LTDS_OFS_START, 32'h02000503);
        bus(1'b1, `LTDS_OFS_DATE, 32'h001a031d);
        sync(3'h0, tm(1, 59, 40), tm(3, 0, 0));
        chk("status", 32'h1, `LTDS_OFS_STATUS);
        bus(1'b1, `LTDS_OFS_CTRL, 32'h0500);
        chk("country", 32'h0500, `LTDS_OFS_CTRL);
        chk("status", 32'h0500, `LTDS_OFS_STATUS);
        chk_val("sec_tick count", 32'h0, 32'(n_tick));
        $display("test daylight done");
        stop_test();
    end
endmodule
`default_nettype wire
